/* core/prescaled_eight_bit_timers.sv */
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module prescaled_eight_bit_timers
	import timer_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int TIMER_W = 8,
	parameter int TIMERS = 4
) (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] address, // register word index
	input wire logic read, // read request
	input wire logic write, // write request
	input wire logic [DATA_W-1:0] writedata, // write data, low byte used
	input wire logic [DATA_W/8-1:0] byteenable, // byte lanes
	output logic [DATA_W-1:0] readdata, // read data
	output logic waitrequest, // stall while high
	input wire logic gear_clock_tick, // gear-derived clock enable
	input wire logic low_clock_tick, // low-frequency clock enable
	input wire logic high_div16_tick, // high clock / 16 enable
	input wire logic external_count_input, // external count pin
	output logic timer_output_pin, // second flip-flop
	output logic irq_timer0, // timer 0 interrupt pulse
	output logic irq_timer1, // timer 1 interrupt pulse
	output logic irq_timer2, // timer 2 interrupt pulse
	output logic irq_timer3, // timer 3 interrupt pulse
	output tap_type prescaler_taps // tap pulses for other timers
);

	typedef struct packed {
		logic waitrequest;
		logic [DATA_W-1:0] readdata;
		logic [7:0] run_control;
		logic [7:0] pair01_mode;
		logic [7:0] pair23_mode;
		logic [3:0][TIMER_W-1:0] period;
		logic [TIMER_W-1:0] period2_buffer;
		logic double_buffer_enable;
		logic [7:0] system_clock_control;
		logic [7:0] flipflop_control;
		logic first_flipflop;
		logic second_flipflop;
		logic [1:0] pre_div;
		logic [8:0] prescaler;
		tap_type taps;
		logic ext_prev;
		logic [3:0] irq;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic [TIMERS-1:0] ch_run;
	logic [TIMERS-1:0] ch_en;
	logic [TIMERS-1:0] ch_clear;
	logic [TIMERS-1:0] ch_hit;
	logic [TIMERS-1:0] ch_ovf;
	logic [TIMERS-1:0][TIMER_W-1:0] ch_count;

	genvar gi;
	generate
		for (gi = 0; gi < TIMERS; gi++) begin : g_timer
			timer_channel #(
				.WIDTH(TIMER_W)
			) u_channel (
				.clock(clock),
				.rst(rst),
				.run(ch_run[gi]),
				.count_en(ch_en[gi]),
				.clear(ch_clear[gi]),
				.period(state_reg.period[gi]),
				.count(ch_count[gi]),
				.hit(ch_hit[gi]),
				.overflow(ch_ovf[gi])
			);
		end
	endgenerate

	assign readdata = state_reg.readdata;
	assign waitrequest = state_reg.waitrequest;
	assign timer_output_pin = state_reg.second_flipflop;
	assign irq_timer0 = state_reg.irq[0];
	assign irq_timer1 = state_reg.irq[1];
	assign irq_timer2 = state_reg.irq[2];
	assign irq_timer3 = state_reg.irq[3];
	assign prescaler_taps = state_reg.taps;

	// Each timer's run bit gates its counter directly
	always_comb begin
		for (int i = 0; i < TIMERS; i++) begin
			ch_run[i] = state_reg.run_control[i];
		end
	end

	// Count pulses; kept apart from the main process so that the lower hit
	// feeding the upper enable never looks like a loop
	always_comb begin
		logic [7:0] mode;
		logic ext_edge;
		logic lo_tick;
		logic hi_tick;
		mode = '0;
		ext_edge = external_count_input && !state_reg.ext_prev;
		lo_tick = 1'b0;
		hi_tick = 1'b0;
		ch_en = '0;
		for (int p = 0; p < 2; p++) begin
			mode = (p == 0) ? state_reg.pair01_mode : state_reg.pair23_mode;
			case (mode[1:0])
				LCLK_EXT: begin
					lo_tick = (p == 0) && ext_edge;
				end
				LCLK_DIV1: begin
					lo_tick = state_reg.taps.div1;
				end
				LCLK_DIV4: begin
					lo_tick = state_reg.taps.div4;
				end
				default: begin
					lo_tick = state_reg.taps.div16;
				end
			endcase
			if (mode[7:6] == MODE_16BIT) begin
				hi_tick = ch_ovf[2 * p];
			end else begin
				case (mode[3:2])
					UCLK_MATCH: begin
						hi_tick = ch_hit[2 * p];
					end
					UCLK_DIV1: begin
						hi_tick = state_reg.taps.div1;
					end
					UCLK_DIV16: begin
						hi_tick = state_reg.taps.div16;
					end
					default: begin
						hi_tick = state_reg.taps.div256;
					end
				endcase
			end
			ch_en[2 * p] = lo_tick;
			ch_en[2 * p + 1] = hi_tick;
		end
	end

	always_comb begin
		logic bus_write;
		logic bus_read_start;
		logic [7:0] wbyte;
		logic [7:0] rbyte;
		logic src_tick;
		logic [7:0] mode;
		logic pair_match;
		logic lo_match;
		logic hi_match;
		logic [1:0] toggle;
		logic cycle_end;
		logic [7:0] pwm_top;
		logic [1:0] cmd;
		state_next = state_reg;
		bus_write = write && !state_reg.waitrequest && byteenable[0];
		bus_read_start = read && state_reg.waitrequest;
		wbyte = writedata[7:0];
		rbyte = 8'h00;
		src_tick = 1'b0;
		mode = '0;
		pair_match = 1'b0;
		lo_match = 1'b0;
		hi_match = 1'b0;
		toggle = '0;
		cycle_end = 1'b0;
		pwm_top = PWM_TOP8;
		cmd = FF_IDLE;
		ch_clear = '0;

		// Bus slave: one wait cycle, then the request completes
		state_next.waitrequest = 1'b1;
		if ((read || write) && state_reg.waitrequest) begin
			state_next.waitrequest = 1'b0;
		end
		case (address)
			RUN_CONTROL_IDX: begin
				rbyte = {state_reg.run_control[7], 1'b1, state_reg.run_control[5:0]};
			end
			PAIR01_IDX: begin
				rbyte = state_reg.pair01_mode;
			end
			PAIR23_IDX: begin
				rbyte = state_reg.pair23_mode;
			end
			DOUBLE_BUF_IDX: begin
				rbyte = {6'h00, state_reg.double_buffer_enable, 1'b0};
			end
			SYSCLK_IDX: begin
				rbyte = state_reg.system_clock_control;
			end
			FLIPFLOP_IDX: begin
				rbyte = {state_reg.flipflop_control[7:6], FF_IDLE,
					state_reg.flipflop_control[3:2], FF_IDLE};
			end
			default: begin
				rbyte = 8'h00;
			end
		endcase
		if (bus_read_start) begin
			state_next.readdata = {{(DATA_W - 8){1'b0}}, rbyte};
		end

		// Prescaler: source pick, divide by four, then the 9-bit chain
		case (state_reg.system_clock_control[1:0])
			SRC_GEAR: begin
				src_tick = gear_clock_tick;
			end
			SRC_LOW: begin
				src_tick = low_clock_tick;
			end
			SRC_HIGH16: begin
				src_tick = high_div16_tick;
			end
			default: begin
				src_tick = 1'b0;
			end
		endcase
		state_next.taps = '0;
		if (!state_reg.run_control[RUN_PRESCALER_BIT]) begin
			state_next.pre_div = '0;
			state_next.prescaler = '0;
		end else if (src_tick) begin
			state_next.pre_div = 2'(state_reg.pre_div + 1'b1);
			if (state_reg.pre_div == PRE_DIV_LAST) begin
				state_next.prescaler = 9'(state_reg.prescaler + 1'b1);
				// Carry out of the low bits gives each tap one pulse per period
				state_next.taps.div1 = (state_reg.prescaler & TAP1_MASK) == TAP1_MASK;
				state_next.taps.div4 = (state_reg.prescaler & TAP4_MASK) == TAP4_MASK;
				state_next.taps.div16 = (state_reg.prescaler & TAP16_MASK) == TAP16_MASK;
				state_next.taps.div256 = state_reg.prescaler == TAP256_MASK;
			end
		end
		state_next.ext_prev = external_count_input;

		// Comparators and cascading, one pass per pair
		state_next.irq = '0;
		for (int p = 0; p < 2; p++) begin
			mode = (p == 0) ? state_reg.pair01_mode : state_reg.pair23_mode;
			if (mode[7:6] == MODE_16BIT) begin
				// Both halves must agree; the zero-period low half matches on wrap,
				// which is also when the upper half steps
				pair_match = ch_hit[2 * p] && ((state_reg.period[2 * p] == '0)
					? (TIMER_W'(ch_count[2 * p + 1] + 1'b1) == state_reg.period[2 * p + 1])
					: (ch_count[2 * p + 1] == state_reg.period[2 * p + 1]));
				ch_clear[2 * p] = pair_match;
				ch_clear[2 * p + 1] = pair_match;
				state_next.irq[2 * p + 1] = pair_match;
				lo_match = pair_match;
				hi_match = pair_match;
			end else begin
				ch_clear[2 * p] = ch_hit[2 * p];
				ch_clear[2 * p + 1] = ch_hit[2 * p + 1];
				state_next.irq[2 * p] = ch_hit[2 * p];
				state_next.irq[2 * p + 1] = ch_hit[2 * p + 1];
				lo_match = ch_hit[2 * p];
				hi_match = ch_hit[2 * p + 1];
			end
			if (p == 0) begin
				toggle[p] = state_reg.flipflop_control[FF1_EN_BIT]
					&& (state_reg.flipflop_control[FF1_SEL_BIT] ? hi_match : lo_match);
			end else begin
				toggle[p] = state_reg.flipflop_control[FF3_EN_BIT]
					&& (state_reg.flipflop_control[FF3_SEL_BIT] ? hi_match : lo_match);
			end
		end

		// Pulse modes of timer 2: the cycle end restarts the counter and is
		// the only moment the buffered period may change
		case (state_reg.pair23_mode[5:4])
			2'h1: begin
				pwm_top = PWM_TOP6;
			end
			2'h2: begin
				pwm_top = PWM_TOP7;
			end
			default: begin
				pwm_top = PWM_TOP8;
			end
		endcase
		if (state_reg.pair23_mode[7:6] == MODE_PPG) begin
			cycle_end = ch_en[2]
				&& (TIMER_W'(ch_count[2] + 1'b1) == state_reg.period[3]);
			ch_clear[2] = cycle_end;
		end else if (state_reg.pair23_mode[7:6] == MODE_PWM) begin
			cycle_end = ch_en[2] && (ch_count[2] == pwm_top);
			ch_clear[2] = cycle_end;
		end
		if (state_reg.double_buffer_enable && cycle_end) begin
			state_next.period[2] = state_reg.period2_buffer;
		end

		// Register writes
		if (bus_write) begin
			case (address)
				RUN_CONTROL_IDX: begin
					state_next.run_control = {wbyte[7], 1'b0, wbyte[5:0]};
				end
				PERIOD0_IDX: begin
					state_next.period[0] = wbyte;
				end
				PERIOD1_IDX: begin
					state_next.period[1] = wbyte;
				end
				PERIOD2_IDX: begin
					state_next.period2_buffer = wbyte;
					if (!state_reg.double_buffer_enable) begin
						state_next.period[2] = wbyte;
					end
				end
				PERIOD3_IDX: begin
					state_next.period[3] = wbyte;
				end
				PAIR01_IDX: begin
					state_next.pair01_mode = wbyte;
				end
				PAIR23_IDX: begin
					state_next.pair23_mode = wbyte;
				end
				DOUBLE_BUF_IDX: begin
					state_next.double_buffer_enable = wbyte[DBUF_ENABLE_BIT];
				end
				SYSCLK_IDX: begin
					state_next.system_clock_control = wbyte;
				end
				FLIPFLOP_IDX: begin
					state_next.flipflop_control = {wbyte[7:6], 2'h0, wbyte[3:2], 2'h0};
				end
				default: begin
					state_next.run_control = state_reg.run_control;
				end
			endcase
		end

		// Flip-flops: a software command in the same cycle as a match wins,
		// since software asked for a definite level
		cmd = (bus_write && address == FLIPFLOP_IDX) ? wbyte[FF1_CMD_LSB +: 2] : FF_IDLE;
		case (cmd)
			FF_CLEAR: begin
				state_next.first_flipflop = 1'b0;
			end
			FF_SET: begin
				state_next.first_flipflop = 1'b1;
			end
			FF_TOGGLE: begin
				state_next.first_flipflop = !state_reg.first_flipflop;
			end
			default: begin
				if (toggle[0]) begin
					state_next.first_flipflop = !state_reg.first_flipflop;
				end
			end
		endcase
		cmd = (bus_write && address == FLIPFLOP_IDX) ? wbyte[FF3_CMD_LSB +: 2] : FF_IDLE;
		case (cmd)
			FF_CLEAR: begin
				state_next.second_flipflop = 1'b0;
			end
			FF_SET: begin
				state_next.second_flipflop = 1'b1;
			end
			FF_TOGGLE: begin
				state_next.second_flipflop = !state_reg.second_flipflop;
			end
			default: begin
				if (toggle[1]) begin
					state_next.second_flipflop = !state_reg.second_flipflop;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg.waitrequest <= 1'b1;
			state_reg.readdata <= '0;
			state_reg.run_control <= RUN_RESET;
			state_reg.pair01_mode <= MODE_RESET;
			state_reg.pair23_mode <= MODE_RESET;
			state_reg.period <= {4{PERIOD_RESET}};
			state_reg.period2_buffer <= PERIOD_RESET;
			state_reg.double_buffer_enable <= 1'b0;
			state_reg.system_clock_control <= SYSCLK_RESET;
			state_reg.flipflop_control <= FF_CTRL_RESET;
			// Documented as undefined; held at zero so the pin is never unknown
			state_reg.first_flipflop <= 1'b0;
			state_reg.second_flipflop <= 1'b0;
			state_reg.pre_div <= '0;
			state_reg.prescaler <= '0;
			state_reg.taps <= '0;
			state_reg.ext_prev <= 1'b0;
			state_reg.irq <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : prescaled_eight_bit_timers

`default_nettype wire

/* core/timer_pkg.sv */
package timer_pkg;

	// Register word indices on the bus; byte address is four times the index
	localparam logic [7:0] RUN_CONTROL_IDX = 8'h20;
	localparam logic [7:0] PERIOD0_IDX = 8'h22;
	localparam logic [7:0] PERIOD1_IDX = 8'h23;
	localparam logic [7:0] PAIR01_IDX = 8'h24;
	localparam logic [7:0] PAIR23_IDX = 8'h25;
	localparam logic [7:0] PERIOD2_IDX = 8'h26;
	localparam logic [7:0] PERIOD3_IDX = 8'h27;
	localparam logic [7:0] FLIPFLOP_IDX = 8'h28;
	localparam logic [7:0] DOUBLE_BUF_IDX = 8'h29;
	localparam logic [7:0] SYSCLK_IDX = 8'h6e;

	// Values after reset
	localparam logic [7:0] RUN_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] SYSCLK_RESET = 8'ha0;
	localparam logic [7:0] FF_CTRL_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'h00;

	// Field positions
	localparam int RUN_PRESCALER_BIT = 7;
	localparam int DBUF_ENABLE_BIT = 1;
	localparam int FF1_CMD_LSB = 0;
	localparam int FF1_EN_BIT = 2;
	localparam int FF1_SEL_BIT = 3;
	localparam int FF3_CMD_LSB = 4;
	localparam int FF3_EN_BIT = 6;
	localparam int FF3_SEL_BIT = 7;

	// Prescaler source codes
	localparam logic [1:0] SRC_GEAR = 2'h0;
	localparam logic [1:0] SRC_LOW = 2'h1;
	localparam logic [1:0] SRC_HIGH16 = 2'h2;

	// Prescaler front divider (divide by 4) and 9-bit chain with its tap masks
	localparam logic [1:0] PRE_DIV_LAST = 2'h3;
	localparam logic [8:0] TAP1_MASK = 9'h001;
	localparam logic [8:0] TAP4_MASK = 9'h007;
	localparam logic [8:0] TAP16_MASK = 9'h01f;
	localparam logic [8:0] TAP256_MASK = 9'h1ff;

	// Lower timer clock codes
	localparam logic [1:0] LCLK_EXT = 2'h0;
	localparam logic [1:0] LCLK_DIV1 = 2'h1;
	localparam logic [1:0] LCLK_DIV4 = 2'h2;
	localparam logic [1:0] LCLK_DIV16 = 2'h3;

	// Upper timer clock codes
	localparam logic [1:0] UCLK_MATCH = 2'h0;
	localparam logic [1:0] UCLK_DIV1 = 2'h1;
	localparam logic [1:0] UCLK_DIV16 = 2'h2;
	localparam logic [1:0] UCLK_DIV256 = 2'h3;

	// Pair mode codes
	localparam logic [1:0] MODE_8BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_PPG = 2'h2;
	localparam logic [1:0] MODE_PWM = 2'h3;

	// Flip-flop command codes; the idle code also is what the field reads back
	localparam logic [1:0] FF_TOGGLE = 2'h0;
	localparam logic [1:0] FF_CLEAR = 2'h1;
	localparam logic [1:0] FF_SET = 2'h2;
	localparam logic [1:0] FF_IDLE = 2'h3;

	// Pulse-width cycle tops for n = 6, 7, 8
	localparam logic [7:0] PWM_TOP6 = 8'h3f;
	localparam logic [7:0] PWM_TOP7 = 8'h7f;
	localparam logic [7:0] PWM_TOP8 = 8'hff;

	typedef struct packed {
		logic div1;
		logic div4;
		logic div16;
		logic div256;
	} tap_type;

endpackage : timer_pkg

/* core/timer_channel.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_channel #(
	parameter int WIDTH = 8
) (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset
	input wire logic run, // 0 holds the counter at zero
	input wire logic count_en, // one-cycle count pulse
	input wire logic clear, // clear instead of counting
	input wire logic [WIDTH-1:0] period, // compare value
	output logic [WIDTH-1:0] count, // counter value
	output logic hit, // counter reaches the period on this pulse
	output logic overflow // counter wraps on this pulse
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} channel_state_type;

	channel_state_type state_reg;
	channel_state_type state_next;

	assign count = state_reg.count;
	// A zero period means a full wrap of the counter
	assign overflow = count_en && (&state_reg.count);
	assign hit = count_en && ((period == '0) ? (&state_reg.count)
		: (WIDTH'(state_reg.count + 1'b1) == period));

	always_comb begin
		state_next = state_reg;
		if (!run) begin
			state_next.count = '0;
		end else if (clear) begin
			state_next.count = '0;
		end else if (count_en) begin
			state_next.count = WIDTH'(state_reg.count + 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : timer_channel

`default_nettype wire

/* bench/prescaled_eight_bit_timers_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module prescaled_eight_bit_timers_sva
	import timer_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset
	input wire logic [7:0] address, // word index
	input wire logic read, // read request
	input wire logic write, // write request
	input wire logic [DATA_W-1:0] readdata, // read data
	input wire logic waitrequest, // stall
	input wire logic irq_timer2, // timer 2 pulse
	input wire tap_type prescaler_taps // tap pulses
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	wire logic rd_take = read && waitrequest;

	AST_ONE_WAIT: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("request not answered after one wait");
	AST_WAIT_SINGLE: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low longer than one cycle");
	AST_WAIT_IDLE: assert property (!(read || write) |=> waitrequest)
		else $error("waitrequest low without a request");
	AST_RUN_BIT6: assert property (rd_take && address == RUN_CONTROL_IDX
		|-> ##2 readdata[6])
		else $error("run control bit 6 read as zero");
	AST_PERIOD_WO: assert property (rd_take && address == PERIOD2_IDX
		|-> ##2 readdata == '0)
		else $error("period register returned contents");
	AST_CMD_ONES: assert property (rd_take && address == FLIPFLOP_IDX
		|-> ##2 readdata[5:4] == 2'h3 && readdata[1:0] == 2'h3)
		else $error("flip-flop command field not read as ones");
	AST_TAP_SPACE: assert property (prescaler_taps.div1
		|=> !prescaler_taps.div1 [*7])
		else $error("divide-1 tap closer than eight cycles");
	AST_TAP_NEST: assert property (prescaler_taps.div256 |-> prescaler_taps.div16
		&& prescaler_taps.div4 && prescaler_taps.div1)
		else $error("slow tap without faster taps");
	AST_IRQ2_SPACE: assert property (irq_timer2 |=> !irq_timer2 [*7])
		else $error("timer 2 interrupt faster than its fastest tap");

	CV_READ: cover property (rd_take && address == RUN_CONTROL_IDX);
	CV_TAP: cover property (prescaler_taps.div256);
	CV_IRQ: cover property (irq_timer2);
endmodule : prescaled_eight_bit_timers_sva

bind prescaled_eight_bit_timers prescaled_eight_bit_timers_sva #(.DATA_W(DATA_W))
	prescaled_eight_bit_timers_sva_inst (.clock(clock), .rst(rst), .address(address),
	.read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
	.irq_timer2(irq_timer2), .prescaler_taps(prescaler_taps));

`default_nettype wire

/* bench/prescaled_eight_bit_timers_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module prescaled_eight_bit_timers_tb_top
	import timer_pkg::*;
;
	logic clock, rst, read, write, waitrequest, p;
	logic gear_clock_tick, low_clock_tick, high_div16_tick, external_count_input;
	logic timer_output_pin, irq_timer0, irq_timer1, irq_timer2, irq_timer3;
	logic [7:0] address, q;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	tap_type prescaler_taps;
	int bad_count, n_compared, irq0_cnt, i, w, cyc, t;
	int ue [4] = '{16, 8, 128, 2048};
	wire logic [7:0] mon = {irq_timer3, irq_timer2, irq_timer1, irq_timer0,
		prescaler_taps.div256, prescaler_taps.div16, prescaler_taps.div4, prescaler_taps.div1};

	prescaled_eight_bit_timers prescaled_eight_bit_timers_inst (.clock(clock), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.gear_clock_tick(gear_clock_tick), .low_clock_tick(low_clock_tick),
		.high_div16_tick(high_div16_tick), .external_count_input(external_count_input),
		.timer_output_pin(timer_output_pin), .irq_timer0(irq_timer0), .irq_timer1(irq_timer1),
		.irq_timer2(irq_timer2), .irq_timer3(irq_timer3), .prescaler_taps(prescaler_taps));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (irq_timer0 === 1'b1)
			irq0_cnt <= irq0_cnt + 1;
	end

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// Request is held until waitrequest is sampled low; no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int n;
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, d};
		byteenable <= be;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			results();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'h1);
		`CHK(q, e)
	endtask : rd

	task automatic wait_pulse(input int b, output int n);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (mon[b] !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			bad_count++;
			results();
		end
	endtask : wait_pulse

	// Spacing between two consecutive pulses, so a partial first interval never counts
	task automatic gap(input int b, input int e);
		int n;
		wait_pulse(b, n);
		wait_pulse(b, n);
		`CHK(n, e)
	endtask : gap

	task automatic quiet(input int b);
		int k;
		k = 0;
		repeat (3) @(posedge clock);
		repeat (40) begin
			@(posedge clock);
			if (mon[b] === 1'b1)
				k++;
		end
		`CHK(k, 0)
	endtask : quiet

	task automatic cmd(input logic [7:0] d, input logic e);
		wr(FLIPFLOP_IDX, d);
		repeat (2) @(posedge clock);
		`CHK(timer_output_pin, e)
	endtask : cmd

	initial begin
		rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		byteenable = 4'h0;
		{high_div16_tick, low_clock_tick, gear_clock_tick} = 3'b001;
		external_count_input = 1'b0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd(RUN_CONTROL_IDX, 8'h40);
		rd(SYSCLK_IDX, 8'ha0);
		rd(DOUBLE_BUF_IDX, 8'h00);
		rd(FLIPFLOP_IDX, 8'h33);
		rd(PAIR01_IDX, 8'h00);
		rd(PAIR23_IDX, 8'h00);
		wr(PERIOD2_IDX, 8'h5a);
		rd(PERIOD2_IDX, 8'h00);
		rd(8'h30, 8'h00);
		bus(1'b1, SYSCLK_IDX, 8'ha2, 4'h0);
		rd(SYSCLK_IDX, 8'ha0);
		quiet(0);
		wr(RUN_CONTROL_IDX, 8'h80);
		rd(RUN_CONTROL_IDX, 8'hc0);
		// The system clock stays high-frequency here, so high/16 is a legal pick
		for (i = 0; i < 3; i++) begin
			wr(SYSCLK_IDX, 8'ha0 | 8'(i));
			{high_div16_tick, low_clock_tick, gear_clock_tick} <= 3'b001 << i;
			gap(0, 8);
			{high_div16_tick, low_clock_tick, gear_clock_tick} <= 3'b001 << ((i + 1) % 3);
			quiet(0);
		end
		wr(SYSCLK_IDX, 8'ha0);
		{high_div16_tick, low_clock_tick, gear_clock_tick} <= 3'b001;
		gap(1, 32);
		gap(2, 128);
		gap(3, 2048);
		wr(RUN_CONTROL_IDX, 8'h00);
		quiet(0);
		wr(PERIOD0_IDX, 8'h03);
		wr(PAIR01_IDX, 8'h01);
		wr(RUN_CONTROL_IDX, 8'h81);
		gap(4, 24);
		wr(RUN_CONTROL_IDX, 8'h80);
		quiet(4);
		wr(PERIOD0_IDX, 8'h00);
		wr(RUN_CONTROL_IDX, 8'h81);
		gap(4, 2048);
		wr(RUN_CONTROL_IDX, 8'h80);
		wr(PAIR01_IDX, 8'h00);
		wr(PERIOD0_IDX, 8'h02);
		wr(RUN_CONTROL_IDX, 8'h81);
		i = irq0_cnt;
		repeat (4) begin
			@(posedge clock) external_count_input <= 1'b1;
			repeat (2) @(posedge clock);
			external_count_input <= 1'b0;
			repeat (2) @(posedge clock);
		end
		repeat (3) @(posedge clock);
		`CHK(irq0_cnt - i, 2)
		wr(RUN_CONTROL_IDX, 8'h80);
		wr(PERIOD1_IDX, 8'h01);
		for (i = 0; i < 4; i++) begin
			wr(RUN_CONTROL_IDX, 8'h80);
			wr(PAIR01_IDX, 8'(i * 4 + 1));
			wr(RUN_CONTROL_IDX, 8'h83);
			gap(5, ue[i]);
		end
		wr(RUN_CONTROL_IDX, 8'h80);
		wr(PAIR01_IDX, 8'h41);
		wr(RUN_CONTROL_IDX, 8'h83);
		gap(5, 2064);
		wr(PERIOD2_IDX, 8'h01);
		for (i = 1; i < 4; i++) begin
			wr(RUN_CONTROL_IDX, 8'h80);
			wr(PAIR23_IDX, 8'(i));
			wr(RUN_CONTROL_IDX, 8'h84);
			gap(6, 8 << (2 * (i - 1)));
		end
		cmd(8'h20, 1'b1);
		cmd(8'h10, 1'b0);
		cmd(8'h00, 1'b1);
		cmd(8'h00, 1'b0);
		wr(PERIOD2_IDX, 8'h02);
		wr(PAIR23_IDX, 8'h01);
		wr(FLIPFLOP_IDX, 8'h70);
		gap(6, 16);
		// One match apart, so a single toggle separates the two samples
		p = timer_output_pin;
		wait_pulse(6, w);
		`CHK(w, 16)
		`CHK(timer_output_pin, ~p)
		wr(FLIPFLOP_IDX, 8'h30);
		gap(6, 16);
		p = timer_output_pin;
		wait_pulse(6, w);
		`CHK(timer_output_pin, p)
		wr(DOUBLE_BUF_IDX, 8'h02);
		rd(DOUBLE_BUF_IDX, 8'h02);
		wr(PERIOD2_IDX, 8'h04);
		gap(6, 16);
		wr(DOUBLE_BUF_IDX, 8'h00);
		wr(PERIOD2_IDX, 8'h04);
		gap(6, 32);
		wr(PERIOD3_IDX, 8'h02);
		wr(PAIR23_IDX, 8'h05);
		wr(RUN_CONTROL_IDX, 8'h8c);
		gap(7, 16);
		// Pulse-width cycle of 64 counts; the buffered period lands only at its end
		wr(RUN_CONTROL_IDX, 8'h88);
		wr(DOUBLE_BUF_IDX, 8'h02);
		wr(PAIR23_IDX, 8'hd1);
		wr(RUN_CONTROL_IDX, 8'h8c);
		gap(6, 512);
		t = cyc;
		wr(PERIOD2_IDX, 8'h24);
		wait_pulse(6, w);
		`CHK(cyc - t, 768)
		results();
	end
endmodule : prescaled_eight_bit_timers_tb_top

`default_nettype wire
